// [rtl/dmacc_channel.sv]
`timescale 1ns/100ps
`default_nettype none

module dmacc_channel
    import dmacc_pkg::*;
#(
    parameter int COUNT_W = DMACC_COUNT_W_DEF
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [DMACC_ADDR_W-1:0] bus_addr,
    input wire logic [7:0] bus_wr_data,
    input wire logic bus_wr_stb,
    input wire logic bus_rd_stb,
    output logic [7:0] bus_rd_data,
    input wire logic [DMACC_NUM_TRIG-1:0] trig_req,
    output logic chan_clk_en,
    output logic xfer_req,
    output logic [COUNT_W-1:0] xfer_index,
    output logic dma_transfer_end_interrupt,
    output logic [1:0] dma_irq_level
);

    generate
        if (COUNT_W < 1 || COUNT_W > 8)
        begin : g_bad_count_w
            $error("dmacc_channel: COUNT_W must lie in 1..8");
        end
    endgenerate

    // an unsupported source code is refused, not stored
    function automatic logic sel_legal(input logic [3:0] sel);
        sel_legal = (sel <= DMACC_SEL_MAX);
    endfunction : sel_legal

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    logic channel_enable_reg;
    logic transfer_in_progress_reg;
    logic dma_end_request_flag_reg;
    logic dma_end_mask_reg;
    logic dma_priority_bit_low_reg;
    logic dma_priority_bit_high_reg;
    logic hold_reg;
    logic pending_reg;
    logic [3:0] sel_reg;
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] remain_reg;
    logic [COUNT_W-1:0] index_reg;
    logic xfer_req_reg;
    logic [7:0] rd_data_reg;
    dmacc_state_t state_reg;
    dmacc_state_t state_next;

    logic wr_ctrl;
    logic wr_flags;
    logic wr_mask;
    logic wr_plo;
    logic wr_phi;
    logic wr_mode;
    logic wr_count;
    logic rd_flags;
    logic arm_req;
    logic sw_trig;
    logic hw_trig;
    logic any_trig;
    logic fire;
    logic last_xfer;
    logic end_event;
    logic [DMACC_NUM_TRIG-1:0] trig_hit;
    logic [3:0] wr_sel;

    assign wr_ctrl = bus_wr_stb && hit(bus_addr, DMACC_OFS_CTRL);
    assign wr_flags = bus_wr_stb && hit(bus_addr, DMACC_OFS_FLAGS);
    assign wr_mask = bus_wr_stb && hit(bus_addr, DMACC_OFS_MASK);
    assign wr_plo = bus_wr_stb && hit(bus_addr, DMACC_OFS_PRIO_LO);
    assign wr_phi = bus_wr_stb && hit(bus_addr, DMACC_OFS_PRIO_HI);
    // setup registers are locked while the channel is disabled
    assign wr_mode = bus_wr_stb && hit(bus_addr, DMACC_OFS_MODE) && channel_enable_reg;
    assign wr_count = bus_wr_stb && hit(bus_addr, DMACC_OFS_COUNT) && channel_enable_reg;
    assign rd_flags = bus_rd_stb && hit(bus_addr, DMACC_OFS_FLAGS);
    assign wr_sel = bus_wr_data[DMACC_MODE_SEL_LSB +: DMACC_MODE_SEL_W];

    // arming needs the channel enabled and idle before this write
    assign arm_req = wr_ctrl && bus_wr_data[DMACC_CTRL_EN_BIT]
                     && bus_wr_data[DMACC_CTRL_BUSY_BIT]
                     && (state_reg == DMACC_ST_IDLE) && (count_reg != '0);

    genvar gi;
    generate
        for (gi = 0; gi < DMACC_NUM_TRIG; gi++)
        begin : g_trig
            assign trig_hit[gi] = trig_req[gi] && (sel_reg == 4'(gi + 1));
        end
    endgenerate

    assign hw_trig = |trig_hit;
    assign sw_trig = wr_mode && bus_wr_data[DMACC_MODE_SWTRIG_BIT];
    assign any_trig = hw_trig || sw_trig || pending_reg;
    // a held trigger waits in pending_reg until hold is released
    assign fire = (state_reg == DMACC_ST_BUSY) && any_trig && !hold_reg;
    assign last_xfer = fire && (remain_reg == COUNT_W'(1));
    // a disable in the same cycle cancels the last transfer, so no end is reported
    assign end_event = last_xfer && (state_next != DMACC_ST_OFF);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            DMACC_ST_OFF:
            begin
                if (wr_ctrl && bus_wr_data[DMACC_CTRL_EN_BIT])
                    state_next = arm_req ? DMACC_ST_BUSY : DMACC_ST_IDLE;
            end
            DMACC_ST_IDLE:
            begin
                if (wr_ctrl && !bus_wr_data[DMACC_CTRL_EN_BIT])
                    state_next = DMACC_ST_OFF;
                else if (arm_req)
                    state_next = DMACC_ST_BUSY;
            end
            DMACC_ST_BUSY:
            begin
                if (wr_ctrl && !bus_wr_data[DMACC_CTRL_EN_BIT])
                    state_next = DMACC_ST_OFF;
                else if (last_xfer)
                    state_next = DMACC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            state_reg <= DMACC_ST_OFF;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            channel_enable_reg <= DMACC_EN_RST;
        else if (wr_ctrl)
            channel_enable_reg <= bus_wr_data[DMACC_CTRL_EN_BIT];
    end

    // busy follows the state machine: high from arming to the last transfer
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            transfer_in_progress_reg <= 1'b0;
        else
            transfer_in_progress_reg <= (state_next == DMACC_ST_BUSY);
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hold_reg <= DMACC_HOLD_RST;
            sel_reg <= DMACC_SEL_RST;
        end
        else if (wr_mode)
        begin
            hold_reg <= bus_wr_data[DMACC_MODE_HOLD_BIT];
            if (sel_legal(wr_sel))
                sel_reg <= wr_sel;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            count_reg <= '0;
        else if (wr_count)
            count_reg <= bus_wr_data[COUNT_W-1:0];
    end

    // requests seen while held are kept, one deep; cleared when the channel stops
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            pending_reg <= 1'b0;
        else if (state_next != DMACC_ST_BUSY)
            pending_reg <= 1'b0;
        else if (fire)
            pending_reg <= 1'b0;
        else if (hold_reg && (hw_trig || sw_trig))
            pending_reg <= 1'b1;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            remain_reg <= '0;
            index_reg <= '0;
        end
        else if (arm_req)
        begin
            remain_reg <= count_reg;
            index_reg <= '0;
        end
        else if (fire && (state_next != DMACC_ST_OFF))
        begin
            remain_reg <= remain_reg - COUNT_W'(1);
            index_reg <= index_reg + COUNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            xfer_req_reg <= 1'b0;
        else
            xfer_req_reg <= fire && (state_next != DMACC_ST_OFF);
    end

    // the completion event wins over a clearing write or read in the same cycle
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            dma_end_request_flag_reg <= DMACC_FLAG_RST;
        else if (end_event)
            dma_end_request_flag_reg <= 1'b1;
        else if (wr_flags)
            dma_end_request_flag_reg <= bus_wr_data[DMACC_DMA_BIT];
        else if (rd_flags)
            dma_end_request_flag_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            dma_end_mask_reg <= DMACC_MASK_RST;
        else if (wr_mask)
            dma_end_mask_reg <= bus_wr_data[DMACC_DMA_BIT];
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dma_priority_bit_low_reg <= DMACC_PRIO_RST;
            dma_priority_bit_high_reg <= DMACC_PRIO_RST;
        end
        else
        begin
            if (wr_plo)
                dma_priority_bit_low_reg <= bus_wr_data[DMACC_DMA_BIT];
            if (wr_phi)
                dma_priority_bit_high_reg <= bus_wr_data[DMACC_DMA_BIT];
        end
    end

    // read data stand in the cycle after the strobe only
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rd_data_reg <= 8'h00;
        else if (!bus_rd_stb)
            rd_data_reg <= 8'h00;
        else
        begin
            rd_data_reg <= 8'h00;
            unique case (bus_addr)
                DMACC_OFS_CTRL:
                begin
                    rd_data_reg[DMACC_CTRL_EN_BIT] <= channel_enable_reg;
                    rd_data_reg[DMACC_CTRL_BUSY_BIT] <= transfer_in_progress_reg;
                end
                DMACC_OFS_FLAGS:
                    rd_data_reg[DMACC_DMA_BIT] <= dma_end_request_flag_reg;
                DMACC_OFS_MASK:
                    rd_data_reg[DMACC_DMA_BIT] <= dma_end_mask_reg;
                DMACC_OFS_PRIO_LO:
                    rd_data_reg[DMACC_DMA_BIT] <= dma_priority_bit_low_reg;
                DMACC_OFS_PRIO_HI:
                    rd_data_reg[DMACC_DMA_BIT] <= dma_priority_bit_high_reg;
                DMACC_OFS_MODE:
                begin
                    rd_data_reg[DMACC_MODE_HOLD_BIT] <= hold_reg;
                    rd_data_reg[DMACC_MODE_SEL_LSB +: DMACC_MODE_SEL_W] <= sel_reg;
                end
                DMACC_OFS_COUNT:
                    rd_data_reg[COUNT_W-1:0] <= count_reg;
                DMACC_OFS_REMAIN:
                    rd_data_reg[COUNT_W-1:0] <= remain_reg;
                default:
                    rd_data_reg <= 8'h00;
            endcase
        end
    end

    assign bus_rd_data = rd_data_reg;
    // drives the enable of an external clock gate cell for the channel
    assign chan_clk_en = channel_enable_reg;
    assign xfer_req = xfer_req_reg;
    assign xfer_index = index_reg;
    assign dma_transfer_end_interrupt = dma_end_request_flag_reg && !dma_end_mask_reg;
    assign dma_irq_level = {dma_priority_bit_high_reg, dma_priority_bit_low_reg};

endmodule : dmacc_channel

`default_nettype wire

// [rtl/dmacc_pkg.sv]
package dmacc_pkg;

    // register offsets on the plain register port
    localparam int DMACC_ADDR_W = 4;
    localparam logic [3:0] DMACC_OFS_CTRL = 4'h0;
    localparam logic [3:0] DMACC_OFS_FLAGS = 4'h1;
    localparam logic [3:0] DMACC_OFS_MASK = 4'h2;
    localparam logic [3:0] DMACC_OFS_PRIO_LO = 4'h3;
    localparam logic [3:0] DMACC_OFS_PRIO_HI = 4'h4;
    localparam logic [3:0] DMACC_OFS_MODE = 4'h5;
    localparam logic [3:0] DMACC_OFS_COUNT = 4'h6;
    localparam logic [3:0] DMACC_OFS_REMAIN = 4'h7;

    // field positions
    localparam int DMACC_CTRL_EN_BIT = 7;
    localparam int DMACC_CTRL_BUSY_BIT = 0;
    localparam int DMACC_DMA_BIT = 3;
    localparam int DMACC_MODE_SWTRIG_BIT = 7;
    localparam int DMACC_MODE_HOLD_BIT = 4;
    localparam int DMACC_MODE_SEL_LSB = 0;
    localparam int DMACC_MODE_SEL_W = 4;

    // reset values
    localparam logic DMACC_EN_RST = 1'b0;
    localparam logic DMACC_FLAG_RST = 1'b0;
    localparam logic DMACC_MASK_RST = 1'b1;
    localparam logic DMACC_PRIO_RST = 1'b1;
    localparam logic DMACC_HOLD_RST = 1'b0;
    localparam logic [3:0] DMACC_SEL_RST = 4'h0;

    // trigger source selection: 0 is software only, above max is prohibited
    localparam logic [3:0] DMACC_SEL_SW_ONLY = 4'h0;
    localparam logic [3:0] DMACC_SEL_MAX = 4'hb;
    localparam int DMACC_NUM_TRIG = 11;

    // the count and remaining registers are read back over the 8-bit data path
    localparam int DMACC_COUNT_W_DEF = 8;

    typedef enum logic [1:0] {
        DMACC_ST_OFF,
        DMACC_ST_IDLE,
        DMACC_ST_BUSY
    } dmacc_state_t;

endpackage : dmacc_pkg

// [sim/dmacc_channel_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module dmacc_channel_checker
    import dmacc_pkg::*;
#(
    parameter int COUNT_W = 8
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [DMACC_ADDR_W-1:0] bus_addr,
    input wire logic [7:0] bus_wr_data,
    input wire logic bus_wr_stb,
    input wire logic bus_rd_stb,
    input wire logic [7:0] bus_rd_data,
    input wire logic [DMACC_NUM_TRIG-1:0] trig_req,
    input wire logic chan_clk_en,
    input wire logic xfer_req,
    input wire logic [COUNT_W-1:0] xfer_index,
    input wire logic dma_transfer_end_interrupt,
    input wire logic [1:0] dma_irq_level
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_wr(logic [3:0] a);
        bus_wr_stb && bus_addr == a;
    endsequence
    sequence s_rd(logic [3:0] a);
        bus_rd_stb && bus_addr == a;
    endsequence
    chk_clk_gate: assert property (
        s_wr(DMACC_OFS_CTRL) |=> chan_clk_en == $past(bus_wr_data[DMACC_CTRL_EN_BIT]))
        else $error("clock enable did not follow the enable bit");
    chk_halted_idle: assert property (
        !chan_clk_en ##1 !chan_clk_en |-> !xfer_req)
        else $error("transfer while channel halted");
    chk_busy_off: assert property (
        s_rd(DMACC_OFS_CTRL) && !chan_clk_en |=> !bus_rd_data[DMACC_CTRL_BUSY_BIT])
        else $error("busy reported on a halted channel");
    chk_flag_read: assert property (
        s_rd(DMACC_OFS_FLAGS) && dma_transfer_end_interrupt |=> bus_rd_data[DMACC_DMA_BIT])
        else $error("end flag read back as 0");
    chk_flag_clear: assert property (
        s_wr(DMACC_OFS_FLAGS) && !bus_wr_data[DMACC_DMA_BIT] |=>
        !dma_transfer_end_interrupt || xfer_req)
        else $error("interrupt stayed after flag clear");
    chk_mask_blocks: assert property (
        s_wr(DMACC_OFS_MASK) && bus_wr_data[DMACC_DMA_BIT] |=> !dma_transfer_end_interrupt)
        else $error("masked interrupt still high");
    chk_prio_low: assert property (
        s_wr(DMACC_OFS_PRIO_LO) |=> dma_irq_level[0] == $past(bus_wr_data[DMACC_DMA_BIT]))
        else $error("priority low bit wrong");
    chk_prio_high: assert property (
        s_wr(DMACC_OFS_PRIO_HI) |=> dma_irq_level[1] == $past(bus_wr_data[DMACC_DMA_BIT]))
        else $error("priority high bit wrong");
    chk_irq_cause: assert property (
        $rose(dma_transfer_end_interrupt) |-> xfer_req
        || $past(bus_wr_stb && (bus_addr == DMACC_OFS_MASK || bus_addr == DMACC_OFS_FLAGS)))
        else $error("interrupt rose without a completion");
endmodule : dmacc_channel_checker
`default_nettype wire

// [sim/dmacc_serial_model.sv]
`timescale 1ns/100ps
`default_nettype none
// serial side: one end-of-transfer pulse per go, on the selected source line only
module dmacc_serial_model
    import dmacc_pkg::*;
#(
    parameter int SRC_BIT = 5
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic go,
    output logic [DMACC_NUM_TRIG-1:0] trig_req
);
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            trig_req <= '0;
        else
            trig_req <= go ? (11'h001 << SRC_BIT) : 11'h000;
    end
endmodule : dmacc_serial_model
`default_nettype wire

// [sim/test_dma_channel_control_irq.sv]
`timescale 1ns/100ps
`default_nettype none
module test_dma_channel_control_irq;
    import dmacc_pkg::*;
    logic ref_clk, rst_b, bus_wr_stb, bus_rd_stb, go, chan_clk_en, xfer_req, irq;
    logic [3:0] bus_addr;
    logic [7:0] bus_wr_data, bus_rd_data, xfer_index;
    logic [10:0] trig_req;
    logic [1:0] lvl;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    dmacc_channel #(.COUNT_W(8)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .bus_addr(bus_addr),
        .bus_wr_data(bus_wr_data), .bus_wr_stb(bus_wr_stb), .bus_rd_stb(bus_rd_stb),
        .bus_rd_data(bus_rd_data), .trig_req(trig_req), .chan_clk_en(chan_clk_en),
        .xfer_req(xfer_req), .xfer_index(xfer_index), .dma_transfer_end_interrupt(irq),
        .dma_irq_level(lvl));
    dmacc_serial_model #(.SRC_BIT(5)) u_far (.ref_clk(ref_clk), .rst_b(rst_b), .go(go),
        .trig_req(trig_req));
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_wr_stb <= 1'b1;
        bus_addr <= a;
        bus_wr_data <= d;
        @(posedge ref_clk);
        bus_wr_stb <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        bus_rd_stb <= 1'b1;
        bus_addr <= a;
        @(posedge ref_clk);
        bus_rd_stb <= 1'b0;
        #1 chk(bus_rd_data, exp);
    endtask : rd
    // the window of six edges covers the model's and the channel's one-cycle latencies
    task automatic fire(input logic exp_x);
        logic seen;
        seen = 1'b0;
        @(posedge ref_clk);
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (6)
        begin
            @(posedge ref_clk);
            #1 seen = seen | (xfer_req === 1'b1);
        end
        chk({7'h0, seen}, {7'h0, exp_x});
    endtask : fire
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            summarize();
        end
    end
    initial
    begin
        rst_b = 1'b0;
        bus_wr_stb = 1'b0;
        bus_rd_stb = 1'b0;
        bus_addr = 4'h0;
        bus_wr_data = 8'h00;
        go = 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(DMACC_OFS_CTRL, 8'h00);
        rd(DMACC_OFS_FLAGS, 8'h00);
        rd(DMACC_OFS_MASK, 8'h08);
        rd(4'hf, 8'h00);
        chk({6'h0, lvl}, 8'h03);
        wr(DMACC_OFS_CTRL, 8'h80);
        chk({7'h0, chan_clk_en}, 8'h01);
        wr(DMACC_OFS_COUNT, 8'h02);
        wr(DMACC_OFS_MODE, 8'h06);
        wr(DMACC_OFS_CTRL, 8'h00);
        chk({7'h0, chan_clk_en}, 8'h00);
        wr(DMACC_OFS_COUNT, 8'h05);
        fire(1'b0);
        wr(DMACC_OFS_CTRL, 8'h80);
        rd(DMACC_OFS_COUNT, 8'h02);
        wr(DMACC_OFS_FLAGS, 8'h00);
        wr(DMACC_OFS_MASK, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(DMACC_OFS_PRIO_LO, i[0] ? 8'h08 : 8'h00);
            wr(DMACC_OFS_PRIO_HI, i[1] ? 8'h08 : 8'h00);
            chk({6'h0, lvl}, 8'(i));
        end
        wr(DMACC_OFS_CTRL, 8'h81);
        rd(DMACC_OFS_CTRL, 8'h81);
        fire(1'b1);
        chk(xfer_index, 8'h01);
        chk({7'h0, irq}, 8'h00);
        fire(1'b1);
        chk(xfer_index, 8'h02);
        chk({7'h0, irq}, 8'h01);
        rd(DMACC_OFS_REMAIN, 8'h00);
        rd(DMACC_OFS_CTRL, 8'h80);
        rd(DMACC_OFS_FLAGS, 8'h08);
        chk({7'h0, irq}, 8'h00);
        wr(DMACC_OFS_MASK, 8'h08);
        wr(DMACC_OFS_CTRL, 8'h81);
        fire(1'b1);
        fire(1'b1);
        chk({7'h0, irq}, 8'h00);
        wr(DMACC_OFS_MASK, 8'h00);
        chk({7'h0, irq}, 8'h01);
        wr(DMACC_OFS_FLAGS, 8'h00);
        chk({7'h0, irq}, 8'h00);
        // held trigger waits as pending, then a software trigger ends the run of two
        wr(DMACC_OFS_CTRL, 8'h81);
        wr(DMACC_OFS_MODE, 8'h16);
        fire(1'b0);
        rd(DMACC_OFS_REMAIN, 8'h02);
        wr(DMACC_OFS_MODE, 8'h06);
        rd(DMACC_OFS_REMAIN, 8'h01);
        chk(xfer_index, 8'h01);
        wr(DMACC_OFS_MODE, 8'h86);
        chk({7'h0, irq}, 8'h01);
        chk(xfer_index, 8'h02);
        rd(DMACC_OFS_CTRL, 8'h80);
        rd(DMACC_OFS_FLAGS, 8'h08);
        chk({7'h0, irq}, 8'h00);
        // an unsupported source code is not stored
        wr(DMACC_OFS_MODE, 8'h0c);
        rd(DMACC_OFS_MODE, 8'h06);
        summarize();
    end
endmodule : test_dma_channel_control_irq
bind dmacc_channel dmacc_channel_checker #(.COUNT_W(COUNT_W)) u_chk (.ref_clk(ref_clk),
    .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr_data(bus_wr_data), .bus_wr_stb(bus_wr_stb),
    .bus_rd_stb(bus_rd_stb), .bus_rd_data(bus_rd_data), .trig_req(trig_req),
    .chan_clk_en(chan_clk_en), .xfer_req(xfer_req), .xfer_index(xfer_index),
    .dma_transfer_end_interrupt(dma_transfer_end_interrupt), .dma_irq_level(dma_irq_level));
`default_nettype wire
